// file: cpu_eoi_regs.svh
// constants of the end-of-interrupt and deactivate write path
// assumes the system register encoding fields arrive already split
`ifndef CPU_EOI_REGS_SVH
`define CPU_EOI_REGS_SVH

// encoding shared by all three write-only registers
`define ENC_OP0          2'h3
`define ENC_OP1          3'h0
`define ENC_CRN          4'hC
// deactivate_interrupt
`define ENC_CRM_DIR      4'hB
`define ENC_OP2_DIR      3'h1
// end_of_interrupt_group0 and end_of_interrupt_group1
`define ENC_CRM_EOI0     4'h8
`define ENC_CRM_EOI1     4'hC
`define ENC_OP2_EOI      3'h1

// field positions
`define REG_WIDTH        32
`define ID_MSB           23
`define ID_WIDTH         24
`define ID_NARROW_WIDTH  16
`define ID_UPPER_ZERO    8'h00

// reset values
`define ID_RESET         24'h000000

// one flop stage from request to answer
`define ANSWER_LATENCY   1

`endif

// file: cpu_eoi_pkg.sv
// types of the end-of-interrupt and deactivate write path
// assumes cpu_eoi_regs.svh is on the include path
`include "cpu_eoi_regs.svh"

package cpu_eoi_pkg;

	typedef enum logic [1:0] {LVL_USER, LVL_KERNEL, LVL_HYP, LVL_MONITOR} level_e;

	typedef enum logic [1:0] {TRAP_NONE, TRAP_KERNEL, TRAP_HYP, TRAP_MONITOR} trap_e;

	typedef enum logic [1:0] {VIRT_NONE, VIRT_EOI0, VIRT_EOI1, VIRT_DIR} virt_e;

	typedef struct packed {
		logic [1:0] op0;
		logic [2:0] op1;
		logic [3:0] crn;
		logic [3:0] crm;
		logic [2:0] op2;
	} sysreg_enc_s;

	typedef struct packed {
		logic monitor_level_present;
		logic identifier_width_field;
		logic completion_mode_bit;
		logic monitor_completion_mode;
		logic secure_kernel_completion_mode;
		logic nonsecure_completion_mode;
		logic group0_routing_override;
		logic group1_routing_override;
		logic system_register_enable;
		logic group0_trap_all;
		logic group1_trap_all;
		logic monitor_fast_irq_routing;
		logic monitor_normal_irq_routing;
	} ctrl_s;

	typedef struct packed {
		logic                   valid;
		logic                   group1;
		logic [`ID_MSB:0]       interrupt_identifier;
	} interrupt_identifier_event_s;

endpackage

// file: cpu_if_eoi_deactivate.sv
// end-of-interrupt and deactivate write handling of one cpu interface
// assumes the core presents one decoded system register write per cycle,
// and the distributor answers the group of the written identifier
// combinationally in the same cycle
// Function
// - deactivate identifier from low field, top ignored
// - identifier width 16 or 24 bits
// - decode deactivate register encoding, write only
// - nonsecure kernel deactivate redirects by group override
// - group 0 write ends group 0 interrupt
// - group 1 write ends group 1 interrupt
// - group 0 override redirects to virtual register
// - group 1 override redirects to virtual register
// - mode 0: drop priority and deactivate
// - mode 1: drop only, deactivate separately
// - no monitor: kernel bit; monitor: monitor bit
// - below monitor: secure or nonsecure bit
// - enable bit 0 traps kernel writes
// - trap-all bits trap nonsecure kernel end writes to hypervisor
// - fast routing traps group 0 ends to monitor; deactivate needs both routing bits
// - normal routing traps group 1 ends to monitor; deactivate needs both routing bits
// - decode both end-of-interrupt register encodings
// - 32-bit, write only, no user access
// - deactivate ignored while mode bit 0
// - deactivate without prior end still deactivates
`include "cpu_eoi_regs.svh"

module cpu_if_eoi_deactivate (
	// clock and reset
	input  wire logic                      clock_i,
	input  wire logic                      reset_i,
	// system register write from the core
	input  wire logic                      write_valid_i,
	input  wire cpu_eoi_pkg::sysreg_enc_s  write_enc_i,
	input  wire logic [`REG_WIDTH-1:0]     write_data_i,
	input  wire cpu_eoi_pkg::level_e       level_i,
	input  wire logic                      secure_i,
	// control bits held elsewhere in the core
	input  wire cpu_eoi_pkg::ctrl_s        ctrl_i,
	// group of the identifier in write_data_i, from the distributor
	input  wire logic                      id_group1_i,
	// completion towards priority logic and distributor
	output cpu_eoi_pkg::interrupt_identifier_event_s      priority_drop_o,
	output cpu_eoi_pkg::interrupt_identifier_event_s      deactivate_o,
	output logic                           deactivate_ignored_o,
	// redirected access towards the virtual interface
	output cpu_eoi_pkg::virt_e             virtual_target_o,
	output logic [`ID_MSB:0]               virtual_id_o,
	// exceptions back to the core
	output cpu_eoi_pkg::trap_e             trap_target_o,
	output logic                           undefined_o
);

	function automatic logic [`ID_MSB:0] clean_id(
		input logic [`REG_WIDTH-1:0] data,
		input logic                  wide
	);
		logic [`ID_MSB:0] id;
		id = data[`ID_MSB:0];
		if (!wide)
			id[`ID_MSB:`ID_NARROW_WIDTH] = `ID_UPPER_ZERO;
		return id;
	endfunction

	function automatic logic mode_select(
		input cpu_eoi_pkg::ctrl_s  c,
		input cpu_eoi_pkg::level_e lvl,
		input logic                sec
	);
		if (!c.monitor_level_present)
			return c.completion_mode_bit;
		if (lvl == cpu_eoi_pkg::LVL_MONITOR)
			return c.monitor_completion_mode;
		return sec ? c.secure_kernel_completion_mode
		           : c.nonsecure_completion_mode;
	endfunction

	// encoding decode
	wire hit_common = write_valid_i && write_enc_i.op0 == `ENC_OP0
		&& write_enc_i.op1 == `ENC_OP1 && write_enc_i.crn == `ENC_CRN;
	wire hit_dir  = hit_common && write_enc_i.crm == `ENC_CRM_DIR
		&& write_enc_i.op2 == `ENC_OP2_DIR;
	wire hit_eoi0 = hit_common && write_enc_i.crm == `ENC_CRM_EOI0
		&& write_enc_i.op2 == `ENC_OP2_EOI;
	wire hit_eoi1 = hit_common && write_enc_i.crm == `ENC_CRM_EOI1
		&& write_enc_i.op2 == `ENC_OP2_EOI;
	wire hit_eoi  = hit_eoi0 || hit_eoi1;
	wire hit_any  = hit_eoi || hit_dir;

	// reserved and narrow-width bits never reach the outputs
	wire [`ID_MSB:0] id_clean =
		clean_id(write_data_i, ctrl_i.identifier_width_field);

	// level and security state
	wire is_user   = level_i == cpu_eoi_pkg::LVL_USER;
	wire is_kernel = level_i == cpu_eoi_pkg::LVL_KERNEL;
	wire is_hyp    = level_i == cpu_eoi_pkg::LVL_HYP;
	wire ns_kernel = is_kernel && !secure_i;
	wire s_kernel  = is_kernel && secure_i;

	// group the access concerns: fixed for end, looked up for deactivate
	wire acc_group1 = hit_eoi1 || (hit_dir && id_group1_i);
	wire override   = acc_group1 ? ctrl_i.group1_routing_override
	                             : ctrl_i.group0_routing_override;
	wire trap_all   = acc_group1 ? ctrl_i.group1_trap_all
	                             : ctrl_i.group0_trap_all;
	wire irq_route  = acc_group1 ? ctrl_i.monitor_normal_irq_routing
	                             : ctrl_i.monitor_fast_irq_routing;
	wire both_route = ctrl_i.monitor_fast_irq_routing
		&& ctrl_i.monitor_normal_irq_routing;
	wire no_ovr     = !ctrl_i.group0_routing_override
		&& !ctrl_i.group1_routing_override;

	wire mode = mode_select(ctrl_i, level_i, secure_i);

	// exceptions in priority order: undefined, kernel, hypervisor, monitor
	wire go_undef  = hit_any && is_user;
	wire go_trap_k = hit_any && is_kernel
		&& !ctrl_i.system_register_enable;
	wire go_trap_h = hit_eoi && ns_kernel && trap_all;
	// redirect only where the guest level owns the group
	wire go_virt   = hit_any && ns_kernel && override;
	wire mon_eoi   = hit_eoi && irq_route
		&& (s_kernel || is_hyp || (ns_kernel && !override));
	wire mon_dir   = hit_dir && both_route
		&& (s_kernel || is_hyp || (ns_kernel && no_ovr));
	wire go_trap_m = ctrl_i.monitor_level_present && (mon_eoi || mon_dir);

	wire blocked = go_undef || go_trap_k || go_trap_h || go_virt
		|| go_trap_m;
	wire perform = hit_any && !blocked;

	// completion effects
	wire drop_nxt = perform && hit_eoi;
	// in split mode a deactivate may come before any end: the
	// distributor still deactivates, the active priority stays
	wire deact_nxt = perform && ((hit_eoi && !mode)
		|| (hit_dir && mode));
	wire ignore_nxt = perform && hit_dir && !mode;

	cpu_eoi_pkg::virt_e virt_nxt;
	assign virt_nxt = !(hit_any && !go_undef && !go_trap_k && !go_trap_h
		&& go_virt) ? cpu_eoi_pkg::VIRT_NONE
		: hit_dir  ? cpu_eoi_pkg::VIRT_DIR
		: hit_eoi1 ? cpu_eoi_pkg::VIRT_EOI1
		:            cpu_eoi_pkg::VIRT_EOI0;

	cpu_eoi_pkg::trap_e trap_nxt;
	assign trap_nxt = go_undef  ? cpu_eoi_pkg::TRAP_NONE
		: go_trap_k ? cpu_eoi_pkg::TRAP_KERNEL
		: go_trap_h ? cpu_eoi_pkg::TRAP_HYP
		: go_virt   ? cpu_eoi_pkg::TRAP_NONE
		: go_trap_m ? cpu_eoi_pkg::TRAP_MONITOR
		:             cpu_eoi_pkg::TRAP_NONE;

	cpu_eoi_pkg::interrupt_identifier_event_s drop_ev;
	cpu_eoi_pkg::interrupt_identifier_event_s deact_ev;
	assign drop_ev  = '{valid: drop_nxt, group1: acc_group1,
		interrupt_identifier: id_clean};
	assign deact_ev = '{valid: deact_nxt, group1: acc_group1,
		interrupt_identifier: id_clean};

	// answers are one-cycle pulses, data follows the write data every cycle
	always_ff @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			priority_drop_o      <= '{valid: 1'b0, group1: 1'b0,
				interrupt_identifier: `ID_RESET};
			deactivate_o         <= '{valid: 1'b0, group1: 1'b0,
				interrupt_identifier: `ID_RESET};
			deactivate_ignored_o <= 1'b0;
			virtual_target_o     <= cpu_eoi_pkg::VIRT_NONE;
			virtual_id_o         <= `ID_RESET;
			trap_target_o        <= cpu_eoi_pkg::TRAP_NONE;
			undefined_o          <= 1'b0;
		end
		else
		begin
			priority_drop_o      <= drop_ev;
			deactivate_o         <= deact_ev;
			deactivate_ignored_o <= ignore_nxt;
			virtual_target_o     <= virt_nxt;
			virtual_id_o         <= id_clean;
			trap_target_o        <= trap_nxt;
			undefined_o          <= go_undef;
		end
	end

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (reset_i);

	// a write that no exception or redirect stops
	sequence s_clean_write;
		hit_any && !blocked;
	endsequence

	sequence s_no_effect;
		!priority_drop_o.valid && !deactivate_o.valid;
	endsequence

	property p_narrow_id;
		hit_any && !ctrl_i.identifier_width_field
			|=> virtual_id_o[`ID_MSB:`ID_NARROW_WIDTH] == `ID_UPPER_ZERO;
	endproperty
	a_narrow_id: assert property (p_narrow_id)
		else $error("narrow identifier leaked upper bits");

	property p_dir_deact;
		s_clean_write ##0 hit_dir ##0 mode
			|=> deactivate_o.valid && !priority_drop_o.valid
			&& deactivate_o.interrupt_identifier == $past(id_clean);
	endproperty
	a_dir_deact: assert property (p_dir_deact)
		else $error("split-mode deactivate not forwarded");

	property p_dir_virtual;
		hit_dir && ns_kernel && ctrl_i.system_register_enable
			&& (id_group1_i ? ctrl_i.group1_routing_override
			                : ctrl_i.group0_routing_override)
			|=> virtual_target_o == cpu_eoi_pkg::VIRT_DIR
			&& !deactivate_o.valid;
	endproperty
	a_dir_virtual: assert property (p_dir_virtual)
		else $error("overridden deactivate not redirected");

	property p_eoi_combined;
		s_clean_write ##0 hit_eoi ##0 !mode
			|=> priority_drop_o.valid && deactivate_o.valid
			&& priority_drop_o.group1 == $past(hit_eoi1);
	endproperty
	a_eoi_combined: assert property (p_eoi_combined)
		else $error("combined end did not drop and deactivate");

	property p_eoi_split;
		s_clean_write ##0 hit_eoi ##0 mode
			|=> priority_drop_o.valid && !deactivate_o.valid;
	endproperty
	a_eoi_split: assert property (p_eoi_split)
		else $error("split-mode end also deactivated");

	property p_eoi_virtual;
		hit_eoi0 && ns_kernel && ctrl_i.system_register_enable
			&& ctrl_i.group0_routing_override && !ctrl_i.group0_trap_all
			|=> virtual_target_o == cpu_eoi_pkg::VIRT_EOI0
			##0 s_no_effect;
	endproperty
	a_eoi_virtual: assert property (p_eoi_virtual)
		else $error("group 0 end not redirected");

	property p_eoi1_virtual;
		hit_eoi1 && ns_kernel && ctrl_i.system_register_enable
			&& ctrl_i.group1_routing_override && !ctrl_i.group1_trap_all
			|=> virtual_target_o == cpu_eoi_pkg::VIRT_EOI1
			##0 s_no_effect;
	endproperty
	a_eoi1_virtual: assert property (p_eoi1_virtual)
		else $error("group 1 end not redirected");

	property p_trap_kernel;
		hit_eoi && is_kernel && !ctrl_i.system_register_enable
			|=> trap_target_o == cpu_eoi_pkg::TRAP_KERNEL ##0 s_no_effect;
	endproperty
	a_trap_kernel: assert property (p_trap_kernel)
		else $error("disabled kernel write not trapped");

	property p_trap_hyp;
		hit_eoi1 && ns_kernel && ctrl_i.system_register_enable
			&& ctrl_i.group1_trap_all
			|=> trap_target_o == cpu_eoi_pkg::TRAP_HYP ##0 s_no_effect;
	endproperty
	a_trap_hyp: assert property (p_trap_hyp)
		else $error("trap-all write not trapped to hypervisor");

	property p_trap_monitor;
		hit_eoi0 && s_kernel && ctrl_i.system_register_enable
			&& ctrl_i.monitor_level_present
			&& ctrl_i.monitor_fast_irq_routing
			|=> trap_target_o == cpu_eoi_pkg::TRAP_MONITOR ##0 s_no_effect;
	endproperty
	a_trap_monitor: assert property (p_trap_monitor)
		else $error("routed group 0 end not trapped to monitor");

	property p_trap_monitor1;
		hit_eoi1 && is_hyp && ctrl_i.monitor_level_present
			&& ctrl_i.monitor_normal_irq_routing
			|=> trap_target_o == cpu_eoi_pkg::TRAP_MONITOR ##0 s_no_effect;
	endproperty
	a_trap_monitor1: assert property (p_trap_monitor1)
		else $error("routed group 1 end not trapped to monitor");

	property p_user_undef;
		hit_any && is_user |=> undefined_o ##0 s_no_effect
			##0 trap_target_o == cpu_eoi_pkg::TRAP_NONE
			&& virtual_target_o == cpu_eoi_pkg::VIRT_NONE;
	endproperty
	a_user_undef: assert property (p_user_undef)
		else $error("user-level write not refused");

	property p_dir_ignored;
		s_clean_write ##0 hit_dir ##0 !mode
			|=> deactivate_ignored_o && !deactivate_o.valid;
	endproperty
	a_dir_ignored: assert property (p_dir_ignored)
		else $error("deactivate in combined mode not ignored");

endmodule // cpu_if_eoi_deactivate

// file: core_model.sv
// processor core model issuing decoded system register writes
// assumes every task is entered at a falling clock edge
`include "cpu_eoi_regs.svh"

module core_model (
	// clock
	input  wire logic                 clock_i,
	// write towards the interface
	output logic                      write_valid_o,
	output cpu_eoi_pkg::sysreg_enc_s  write_enc_o,
	output logic [31:0]               write_data_o,
	output cpu_eoi_pkg::level_e       level_o,
	output logic                      secure_o,
	output logic                      id_group1_o
);
	timeunit 1ns;
	timeprecision 1ns;

	initial
	begin
		write_valid_o = 1'b0;
		write_enc_o = '0;
		write_data_o = 32'h00000000;
		level_o = cpu_eoi_pkg::LVL_USER;
		secure_o = 1'b0;
		id_group1_o = 1'b0;
	end

	// one write held for exactly one taking edge; rg 3 is an unused crm
	// software hands back the acknowledged id
	// and deactivates separately in split mode
	task automatic put(input logic [1:0] rg, input logic [1:0] lvl,
		input logic sec, input logic [31:0] data, input logic grp);
		logic [3:0] crm;
		crm = (rg == 2'h0) ? `ENC_CRM_EOI0 : (rg == 2'h1) ? `ENC_CRM_EOI1 :
			(rg == 2'h2) ? `ENC_CRM_DIR : 4'hA;
		write_valid_o = 1'b1;
		write_enc_o = '{`ENC_OP0, `ENC_OP1, `ENC_CRN, crm, `ENC_OP2_EOI};
		write_data_o = data;
		level_o = cpu_eoi_pkg::level_e'(lvl);
		secure_o = sec;
		id_group1_o = grp;
		@(negedge clock_i);
	endtask

	// released lines flip so a stale value never looks like a fresh one
	task automatic idle();
		write_valid_o = 1'b0;
		write_data_o = ~write_data_o;
		id_group1_o = ~id_group1_o;
		@(negedge clock_i);
	endtask
endmodule // core_model

// file: cpu_if_eoi_deactivate_tb.sv
// self-checking bench of the end-of-interrupt and deactivate path
// assumes core_model drives the writes and stands in for the group lookup
module cpu_if_eoi_deactivate_tb;
	timeunit 1ns;
	timeprecision 1ns;

	typedef struct packed {
		logic [1:0]  rg;
		logic [1:0]  lvl;
		logic        sec;
		logic [12:0] ctl;
		logic        grp;
		logic        drop;
		logic        deact;
		logic        ign;
		logic [1:0]  trap;
		logic [1:0]  virt;
		logic        und;
	} row_s;

	localparam logic [31:0] DATA = 32'hA5F1E2D3;
	localparam logic [1:0] E0 = 2'h0, E1 = 2'h1, DR = 2'h2, XX = 2'h3;
	localparam logic [1:0] US = 2'h0, KL = 2'h1, HY = 2'h2, MN = 2'h3;
	localparam logic [1:0] T0 = 2'h0, TK = 2'h1, TH = 2'h2, TM = 2'h3;
	localparam logic [1:0] V0 = 2'h0, VA = 2'h1, VB = 2'h2, VD = 2'h3;
	localparam logic Y = 1'b1, N = 1'b0;

	logic                          clock_i = 1'b0;
	logic                          reset_i = 1'b1;
	cpu_eoi_pkg::ctrl_s            ctrl_i = '0;
	logic                          write_valid;
	cpu_eoi_pkg::sysreg_enc_s      write_enc;
	logic [31:0]                   write_data;
	cpu_eoi_pkg::level_e           level;
	logic                          secure;
	logic                          id_group1;
	cpu_eoi_pkg::interrupt_identifier_event_s     drop_o;
	cpu_eoi_pkg::interrupt_identifier_event_s     deact_o;
	logic                          ign_o;
	cpu_eoi_pkg::virt_e            virt_o;
	logic [23:0]                   virt_id_o;
	cpu_eoi_pkg::trap_e            trap_o;
	logic                          und_o;
	logic [7:0]                    outs;
	logic [23:0]                   id_x;
	int                            miscompares = 0;
	int                            n_tests = 0;
	int                            cycles = 0;
	row_s                          rows [19];

	assign outs = {drop_o.valid, deact_o.valid, ign_o, virt_o, trap_o, und_o};

	always #25 clock_i = ~clock_i;

	core_model i_core_model (.clock_i(clock_i), .write_valid_o(write_valid),
		.write_enc_o(write_enc), .write_data_o(write_data),
		.level_o(level), .secure_o(secure), .id_group1_o(id_group1));

	cpu_if_eoi_deactivate i_cpu_if_eoi_deactivate (.clock_i(clock_i),
		.reset_i(reset_i), .write_valid_i(write_valid),
		.write_enc_i(write_enc), .write_data_i(write_data), .level_i(level),
		.secure_i(secure), .ctrl_i(ctrl_i), .id_group1_i(id_group1),
		.priority_drop_o(drop_o), .deactivate_o(deact_o),
		.deactivate_ignored_o(ign_o), .virtual_target_o(virt_o),
		.virtual_id_o(virt_id_o), .trap_target_o(trap_o),
		.undefined_o(und_o));

	task automatic chk(input string what, input logic [23:0] seen,
		input logic [23:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// a hang costs a mismatch and ends the run
	always @(posedge clock_i)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			miscompares++;
			report_and_stop();
		end
	end

	initial
	begin
		rows[0]  = '{E0,KL,Y,13'h0810,N,Y,Y,N,T0,V0,N}; // both
		rows[1]  = '{E1,KL,N,13'h0C10,Y,Y,N,N,T0,V0,N}; // drop
		rows[2]  = '{DR,KL,N,13'h0C10,N,N,Y,N,T0,V0,N}; // dir
		rows[3]  = '{DR,KL,N,13'h0810,N,N,N,Y,T0,V0,N}; // ignored
		rows[4]  = '{E0,US,N,13'h0810,N,N,N,N,T0,V0,Y}; // user
		rows[5]  = '{E1,KL,Y,13'h0800,Y,N,N,N,TK,V0,N}; // enable
		rows[6]  = '{E0,KL,N,13'h0818,N,N,N,N,TH,V0,N}; // trap-all
		rows[7]  = '{E1,KL,N,13'h0814,Y,N,N,N,TH,V0,N}; // trap-all
		rows[8]  = '{E0,KL,N,13'h0850,N,N,N,N,T0,VA,N}; // virtual
		rows[9]  = '{E1,KL,N,13'h0830,Y,N,N,N,T0,VB,N}; // virtual
		rows[10] = '{DR,KL,N,13'h0C30,Y,N,N,N,T0,VD,N}; // virtual
		rows[11] = '{DR,KL,N,13'h0C30,N,N,Y,N,T0,V0,N}; // direct
		rows[12] = '{E0,KL,Y,13'h1812,N,N,N,N,TM,V0,N}; // monitor
		rows[13] = '{E1,HY,N,13'h1811,Y,N,N,N,TM,V0,N}; // monitor
		rows[14] = '{E1,MN,Y,13'h1A10,Y,Y,N,N,T0,V0,N}; // mode
		rows[15] = '{E0,KL,Y,13'h1910,N,Y,N,N,T0,V0,N}; // secure
		rows[16] = '{E0,KL,N,13'h1910,N,Y,Y,N,T0,V0,N}; // nonsecure
		rows[17] = '{XX,KL,Y,13'h0810,N,N,N,N,T0,V0,N}; // other
		rows[18] = '{E1,KL,Y,13'h0010,Y,Y,Y,N,T0,V0,N}; // narrow
		repeat (16) @(negedge clock_i);
		chk("outputs in reset", outs, 24'h0);
		reset_i = 1'b0;
		$display("reset test done");
		foreach (rows[i])
		begin
			ctrl_i = cpu_eoi_pkg::ctrl_s'(rows[i].ctl);
			id_x = rows[i].ctl[11] ? DATA[23:0] : {8'h00, DATA[15:0]};
			i_core_model.put(rows[i].rg, rows[i].lvl, rows[i].sec, DATA,
				rows[i].grp);
			chk("outputs", outs, {rows[i].drop, rows[i].deact, rows[i].ign,
				rows[i].virt, rows[i].trap, rows[i].und});
			if (rows[i].drop)
			begin
				chk("drop id", drop_o.interrupt_identifier, id_x);
				chk("drop group", drop_o.group1, rows[i].rg[0]);
			end
			if (rows[i].deact)
			begin
				chk("deactivate id", deact_o.interrupt_identifier, id_x);
				chk("deactivate group", deact_o.group1, (rows[i].rg == DR) ?
					rows[i].grp : rows[i].rg[0]);
			end
			if (rows[i].virt != V0)
				chk("virtual id", virt_id_o, id_x);
			i_core_model.idle();
			chk("quiet", outs, 24'h0);
			$display("row %0d done", i);
		end
		// back to back ends of both groups, no idle cycle between them
		ctrl_i = cpu_eoi_pkg::ctrl_s'(13'h0C10);
		i_core_model.put(E0, KL, Y, DATA, N);
		chk("first drop", {drop_o.valid, drop_o.group1}, 24'h2);
		i_core_model.put(E1, KL, Y, DATA, Y);
		chk("second drop", {drop_o.valid, drop_o.group1}, 24'h3);
		chk("no deactivate", deact_o.valid, 24'h0);
		i_core_model.put(DR, KL, Y, DATA, Y);
		chk("late deactivate", outs, 24'h40);
		i_core_model.idle();
		$display("back to back test done");
		// reset while an answer stands must clear it at once
		i_core_model.put(E0, KL, Y, DATA, N);
		reset_i = 1'b1;
		#1;
		chk("mid reset", outs, 24'h0);
		@(negedge clock_i);
		reset_i = 1'b0;
		i_core_model.idle();
		chk("after reset", outs, 24'h0);
		$display("mid-run reset test done");
		report_and_stop();
	end
endmodule // cpu_if_eoi_deactivate_tb
